// *** design/ldc_i2c_ctrl.sv ***
`timescale 1ns/1ns
`include "ldc_map.svh"

// What this block does
// - the target answers only to address 1001111 with the write bit low.
// - the target never drives data, only acknowledge bits.
// - bits 7 and 6 of the control register are reserved.
// - bit 5 low selects normal mode with both sinks adjustable.
// - bit 5 high disables sink one and fixes sink two at 450 uA.
// - bits 4 to 0 are a binary weighted current code.
// - the current field is latched on the eighth clock of the data byte.
// - an all-zero register turns the pump off and both sinks off.
// - indicator mode stops the pump and detaches sink one.
// - in indicator mode sink two ignores the programmed field.
// - each code step is sixteen times the reference current.
// - overvoltage halts the pump while present, never latching.
module ldc_i2c_ctrl (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               clk_en_in,
  input  wire logic               scl_in,
  input  wire logic               sda_in,
  output logic                    sda_out,
  output logic                    sda_oe_n_out,
  input  wire logic               overvoltage_monitor_in,
  output logic [7:0]              led_control_reg_out,
  output ldc_pkg::ldc_led_ctrl_t  led_ctrl_out
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic [2:0] ovp_sync_q;
  logic       scl_q;
  logic       sda_q;
  logic       ovp_q;

  // three stages; a change counts once stages two and three agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      ovp_sync_q <= 3'h0;
    end else if (clk_en_in) begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
      ovp_sync_q <= {ovp_sync_q[1:0], overvoltage_monitor_in};
    end
  end

  // filtered levels, held until stages agree
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      ovp_q <= 1'b0;
    end else if (clk_en_in) begin
      if (scl_sync_q[1] == scl_sync_q[2]) begin
        scl_q <= scl_sync_q[2];
      end
      if (sda_sync_q[1] == sda_sync_q[2]) begin
        sda_q <= sda_sync_q[2];
      end
      if (ovp_sync_q[1] == ovp_sync_q[2]) begin
        ovp_q <= ovp_sync_q[2];
      end
    end
  end

  // ************************************************************
  // bus events
  // ************************************************************
  logic scl_d1_q;
  logic sda_d1_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_d1_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else if (clk_en_in) begin
      scl_d1_q <= scl_q;
      sda_d1_q <= sda_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // start and stop are data edges while the clock is high
  assign scl_rise = scl_q & ~scl_d1_q;
  assign scl_fall = ~scl_q & scl_d1_q;
  assign start_ev = scl_q & scl_d1_q & sda_d1_q & ~sda_q;
  assign stop_ev  = scl_q & scl_d1_q & ~sda_d1_q & sda_q;

  // ************************************************************
  // frame state machine
  // ************************************************************
  ldc_pkg::ldc_state_t state_q;
  ldc_pkg::ldc_state_t ack_ret_q;
  logic [2:0]          bit_cnt_q;
  logic [7:0]          shift_q;
  logic                ack_drive_q;
  logic [7:0]          ctrl_q;
  logic [7:0]          byte_in;

  assign byte_in = {shift_q[6:0], sda_q};

  // true when the received byte is our write address
  function automatic logic addr_match(input logic [7:0] b);
    addr_match = (b[7:1] == `LDC_DEV_ADDR) && !b[0];
  endfunction

  // bit counter and shifter sample on clock rise
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_q <= `LDC_BIT_FIRST;
      shift_q   <= 8'h00;
    end else if (clk_en_in) begin
      if (start_ev) begin
        bit_cnt_q <= `LDC_BIT_FIRST;
      end else if (scl_rise && (state_q != ldc_pkg::LDC_ACK)) begin
        shift_q   <= byte_in;
        bit_cnt_q <= bit_cnt_q - 3'h1;
      end
    end
  end

  // state moves; ack bits are driven between falling edges
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q     <= ldc_pkg::LDC_IDLE;
      ack_ret_q   <= ldc_pkg::LDC_IDLE;
      ack_drive_q <= 1'b0;
    end else if (clk_en_in) begin
      if (start_ev) begin
        state_q     <= ldc_pkg::LDC_ADDR;
        ack_drive_q <= 1'b0;
      end else if (stop_ev) begin
        state_q     <= ldc_pkg::LDC_IDLE;
        ack_drive_q <= 1'b0;
      end else begin
        case (state_q)
          ldc_pkg::LDC_ADDR: begin
            if (scl_rise && bit_cnt_q == `LDC_BIT_LAST) begin
              if (addr_match(byte_in)) begin
                state_q   <= ldc_pkg::LDC_ACK;
                ack_ret_q <= ldc_pkg::LDC_REGA;
              end else begin
                state_q   <= ldc_pkg::LDC_SKIP;
              end
            end
          end
          ldc_pkg::LDC_REGA: begin
            if (scl_rise && bit_cnt_q == `LDC_BIT_LAST) begin
              state_q <= ldc_pkg::LDC_ACK;
              // other register addresses are acked but discard data
              ack_ret_q <= (byte_in == `LDC_REG_ADDR) ?
                           ldc_pkg::LDC_DATA : ldc_pkg::LDC_SKIP;
            end
          end
          ldc_pkg::LDC_DATA: begin
            if (scl_rise && bit_cnt_q == `LDC_BIT_LAST) begin
              state_q   <= ldc_pkg::LDC_ACK;
              ack_ret_q <= ldc_pkg::LDC_SKIP;
            end
          end
          ldc_pkg::LDC_ACK: begin
            // first fall after the eighth bit starts ack, next ends it
            if (scl_fall) begin
              if (!ack_drive_q) begin
                ack_drive_q <= 1'b1;
              end else begin
                ack_drive_q <= 1'b0;
                state_q     <= ack_ret_q;
              end
            end
          end
          ldc_pkg::LDC_IDLE,
          ldc_pkg::LDC_SKIP: begin
            state_q <= state_q;
          end
          default: begin
            state_q     <= ldc_pkg::LDC_IDLE;
            ack_drive_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // open drain data pin: only ever pulled low for ack
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~ack_drive_q;

  // ************************************************************
  // control register
  // ************************************************************
  // whole byte latched on the eighth clock rise, not at stop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_q <= `LDC_CTRL_RESET;
    end else if (clk_en_in) begin
      if (!start_ev && !stop_ev && state_q == ldc_pkg::LDC_DATA &&
          scl_rise && bit_cnt_q == `LDC_BIT_LAST) begin
        ctrl_q <= byte_in;
      end
    end
  end

  // reserved bits are stored and read out on led_control_reg_out but drive no analog control
  assign led_control_reg_out = ctrl_q;

  // ************************************************************
  // analog controls
  // ************************************************************
  logic mode_ind;
  logic all_zero;

  assign mode_ind = ctrl_q[`LDC_MODE_BIT];
  // reserved bits must not keep the pump alive, so they are left out
  assign all_zero = (ctrl_q[`LDC_MODE_BIT:0] == 6'h00);

  // output decode registered so it changes glitch free
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      led_ctrl_out <= '0;
    end else if (clk_en_in) begin
      // pump off when zero, in indicator mode, or overvoltage
      led_ctrl_out.pump_on <= !all_zero && !mode_ind &&
                              !ovp_q;
      led_ctrl_out.first_sink_on  <= !all_zero && !mode_ind;
      led_ctrl_out.second_sink_on <= !all_zero;
      led_ctrl_out.second_sink_fixed <= mode_ind;
      // weight x16 of reference per lsb applied in the mirror
      led_ctrl_out.current_code <= mode_ind ? 5'h00 :
                                   ctrl_q[`LDC_CODE_MSB:0];
    end
  end

endmodule

// *** include/ldc_map.svh ***
`ifndef LDC_MAP_SVH
`define LDC_MAP_SVH
`define LDC_DEV_ADDR      7'h4f
`define LDC_REG_ADDR      8'h01
`define LDC_CTRL_RESET    8'h00
`define LDC_MODE_BIT      5
`define LDC_CODE_MSB      4
`define LDC_BIT_LAST      3'h0
`define LDC_BIT_FIRST     3'h7
`endif

// *** include/ldc_pkg.sv ***
package ldc_pkg;
  // one-hot frame states
  typedef enum logic [5:0] {
    LDC_IDLE  = 6'h01,
    LDC_ADDR  = 6'h02,
    LDC_REGA  = 6'h04,
    LDC_DATA  = 6'h08,
    LDC_ACK   = 6'h10,
    LDC_SKIP  = 6'h20
  } ldc_state_t;

  // analog control outputs
  typedef struct packed {
    logic       pump_on;
    logic       first_sink_on;
    logic       second_sink_on;
    logic       second_sink_fixed;
    logic [4:0] current_code;
  } ldc_led_ctrl_t;
endpackage

// *** dv/ldc_i2c_ctrl_assertions.sv ***
`timescale 1ns/1ns
// ****************
// port checker
// ****************
module ldc_i2c_ctrl_assertions (
  input wire logic                   clk_in,
  input wire logic                   rst_n_in,
  input wire logic                   clk_en_in,
  input wire logic                   scl_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe_n_out,
  input wire logic                   overvoltage_monitor_in,
  input wire logic [7:0]             led_control_reg_out,
  input wire ldc_pkg::ldc_led_ctrl_t led_ctrl_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // short aliases; outputs follow the register one clock later
  logic [7:0]             r;
  ldc_pkg::ldc_led_ctrl_t o;
  assign r = led_control_reg_out;
  assign o = led_ctrl_out;
  a_sda_never_high: assert property (!sda_out)
    else $error("data line driven high");
  a_indicator_fixes_sink: assert property ($past(r[5]) |->
    !o.pump_on && !o.first_sink_on && o.second_sink_on && o.second_sink_fixed)
    else $error("indicator outputs wrong");
  a_indicator_no_code: assert property ($past(r[5]) |->
    o.current_code == 5'h00) else $error("code used in indicator");
  // reserved bits alone must leave everything off
  a_zero_all_off: assert property (
    $past(r[5:0]) == 6'h00 |-> o == '0)
    else $error("zero register left outputs on");
  a_normal_code: assert property (!$past(r[5]) &&
    $past(r[4:0]) != 5'h00 |-> o.first_sink_on && o.second_sink_on &&
    !o.second_sink_fixed && o.current_code == $past(r[4:0]))
    else $error("normal outputs wrong");
  a_overvoltage_halts: assert property (
    overvoltage_monitor_in [*8] |-> !o.pump_on) else $error("pump ran");
  a_ack_in_low: assert property ($fell(sda_oe_n_out) |-> !scl_in)
    else $error("ack began with clock high");
  a_ack_holds: assert property (
    $fell(sda_oe_n_out) |=> !sda_oe_n_out [*8]) else $error("ack short");
  a_latch_on_clock: assert property ($changed(r) |->
    scl_in && sda_oe_n_out) else $error("latch outside 8th clock");
  // a low enable must hold every output where it was
  a_freeze_holds: assert property (!clk_en_in |=>
    $stable(r) && $stable(o) && $stable(sda_oe_n_out))
    else $error("state moved while frozen");
  c_indicator_entered: cover property ($rose(r[5]));
  c_ack_seen: cover property ($fell(sda_oe_n_out));
  c_pump_halted: cover property (overvoltage_monitor_in && $fell(o.pump_on));
endmodule

bind ldc_i2c_ctrl ldc_i2c_ctrl_assertions u_chk (.clk_in, .rst_n_in, .clk_en_in,
  .scl_in, .sda_out, .sda_oe_n_out, .overvoltage_monitor_in,
  .led_control_reg_out, .led_ctrl_out);

// *** dv/ldc_host_model.sv ***
`timescale 1ns/1ns
// ****************
// host bus master
// ****************
module ldc_host_model (
  input  wire logic clk_in,
  input  wire logic dev_sda_in,
  input  wire logic dev_oe_n_in,
  output logic      scl_out,
  output logic      sda_out
);
  localparam int H = 10; // clocks per phase, twice the minimum
  logic rel_q = 1'b1; // host open drain, high = released
  // wired-and with pull-up, so a free line reads high
  assign sda_out = rel_q & (dev_oe_n_in | dev_sda_in);
  initial scl_out = 1'b1;
  // pins move just after an edge, then hold
  task automatic ph(input logic c, input logic d);
    @(posedge clk_in);
    scl_out <= c;
    rel_q <= d;
    repeat (H) @(posedge clk_in);
  endtask
  // data moves only inside a low phase, never beside a clock edge
  task automatic put(input logic [7:0] b, output logic a);
    for (int i = 7; i >= 0; i--) begin
      ph(1'b0, rel_q);
      ph(1'b0, b[i]);
      ph(1'b1, b[i]);
    end
    ph(1'b0, rel_q);
    ph(1'b0, 1'b1);
    ph(1'b1, 1'b1);
    a = !sda_out;
  endtask
  // start, three bytes, stop
  task automatic frame(input logic [23:0] f, output logic [2:0] ak);
    ph(1'b1, 1'b0);
    put(f[23:16], ak[2]);
    put(f[15:8], ak[1]);
    put(f[7:0], ak[0]);
    ph(1'b0, 1'b0);
    ph(1'b1, 1'b0);
    ph(1'b1, 1'b1);
  endtask
endmodule

// *** dv/ldc_i2c_ctrl_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin \
  checked++; \
  if ((a) !== (b)) begin \
    n_errors++; \
    $display("CHECK FAILED %0t got %h want %h", $time, a, b); \
  end \
end
// ****************
// bench top
// ****************
module ldc_i2c_ctrl_tb_top;
  localparam logic [7:0] CORNER [5] = '{8'h1e, 8'h00, 8'h3e, 8'h01, 8'hc5};
  logic                   clk_in = 1'b0;
  logic                   rst_n_in = 1'b0;
  logic                   ov_q = 1'b0;
  logic                   en_q = 1'b1;
  logic                   scl, sda, sda_o, oe_n;
  logic [7:0]             reg_o, v;
  logic [2:0]             ak;
  ldc_pkg::ldc_led_ctrl_t led_o;
  int                     n_errors = 0;
  int                     checked = 0;
  int                     seed = 70551;
  always #5 clk_in = ~clk_in;
  ldc_i2c_ctrl uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(en_q),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_o), .sda_oe_n_out(oe_n),
    .overvoltage_monitor_in(ov_q), .led_control_reg_out(reg_o),
    .led_ctrl_out(led_o));
  ldc_host_model host (.clk_in(clk_in), .dev_sda_in(sda_o),
    .dev_oe_n_in(oe_n), .scl_out(scl), .sda_out(sda));
  // expected outputs with no overvoltage; top two bits play no part
  function automatic ldc_pkg::ldc_led_ctrl_t exp_led(input logic [7:0] r);
    ldc_pkg::ldc_led_ctrl_t e;
    e = '0;
    if (r[5]) begin
      e.second_sink_on = 1'b1;
      e.second_sink_fixed = 1'b1;
    end else if (r[4:0] != 5'h00) begin
      e = {4'he, r[4:0]};
    end
    return e;
  endfunction
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // corners first, then random codes held within range
  initial begin
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    `CHK(reg_o, 8'h00)
    for (int k = 0; k < 14; k++) begin
      v = 8'($random(seed)) & 8'h3f;
      if (v[4:0] > 5'h1e) v[4:0] = 5'h1e;
      if (k < 5) v = CORNER[k];
      host.frame({8'h9e, 8'h01, v}, ak);
      `CHK(ak, 3'b111)
      `CHK(reg_o, v)
      `CHK(led_o, exp_led(v))
    end
    host.frame({8'h9c, 8'h01, 8'h07}, ak);
    `CHK(ak, 3'b000)
    host.frame({8'h9f, 8'h01, 8'h07}, ak);
    `CHK(ak, 3'b000)
    host.frame({8'h9e, 8'h02, 8'h07}, ak);
    `CHK(ak, 3'b110)
    `CHK(reg_o, v)
    // enable low from an idle bus: a whole frame must go by unseen
    en_q <= 1'b0;
    host.frame({8'h9e, 8'h01, 8'h15}, ak);
    `CHK(ak, 3'b000)
    `CHK(reg_o, v)
    en_q <= 1'b1;
    host.frame({8'h9e, 8'h01, 8'h0a}, ak);
    `CHK(reg_o, 8'h0a)
    ov_q <= 1'b1;
    for (int t = 0; t < 20 && led_o.pump_on !== 1'b0; t++) @(posedge clk_in);
    `CHK(led_o.pump_on, 1'b0)
    ov_q <= 1'b0;
    for (int t = 0; t < 20 && led_o.pump_on !== 1'b1; t++) @(posedge clk_in);
    `CHK(led_o, exp_led(8'h0a))
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    `CHK(led_o, exp_led(8'h00))
    `CHK(oe_n, 1'b1)
    conclude();
  end
endmodule
